// file: shared/ccb_pkg.sv
// Package: register map, field layout and carrier types for chroma/hanc bases
package ccb_pkg;
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  // Per-channel block of five words
  localparam logic [7:0] OFS_TOP_CHROMA = 8'h00;
  localparam logic [7:0] OFS_BOT_CHROMA = 8'h04;
  localparam logic [7:0] OFS_TOP_HANC   = 8'h08;
  localparam logic [7:0] OFS_BOT_HANC   = 8'h0C;
  localparam logic [7:0] OFS_MODE       = 8'h10;
  localparam logic [7:0] CH_STRIDE      = 8'h20;
  localparam logic [7:0] OFS_MASK       = 8'h1F;
  localparam logic [7:0] CH_SEL_BIT     = 8'h05;
  // Mode register fields
  localparam int unsigned MODE_YC_MUX_BIT = 0;
  localparam int unsigned MODE_FIELD_BIT  = 1;
  localparam logic [31:0] MODE_MASK       = 32'h0000_0001;
  localparam logic [31:0] BASE_RESET      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic        FIELD_TOP       = 1'h0;

  // Bases handed to the capture writer at a field start
  typedef struct packed {
    logic [31:0] chroma_base;
    logic [31:0] hanc_base;
    logic        chroma_valid;
  } ccb_field_base_t;
endpackage : ccb_pkg

// file: core/ccb_regs.sv
// Chroma and horizontal ancillary area start registers, AXI4-Lite slave
`timescale 1ns/1ps
module ccb_regs #(
  parameter int unsigned NCH = ccb_pkg::NUM_CH
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ccb_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ccb_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [NCH-1:0]                field_start,
  input  wire logic [NCH-1:0]                field_is_bottom,
  output ccb_pkg::ccb_field_base_t [NCH-1:0] field_base
);
  logic [31:0]       top_field_chroma_base    [NCH];
  logic [31:0]       bottom_field_chroma_base [NCH];
  logic [31:0]       top_field_hanc_base      [NCH];
  logic [31:0]       bottom_field_hanc_base   [NCH];
  logic [NCH-1:0]    yc_mux_mode;
  logic [NCH-1:0]    field_cur;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_hit;
  logic [31:0]       rd_word;
  logic              rd_hit;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // Write address and data taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr       <= '0;
    end else if (wr_go) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (wr_go) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // Decode of the held write address
  always_comb begin
    wr_hit = 1'b0;
    if (int'(aw_addr >> ccb_pkg::CH_SEL_BIT) >= NCH) begin
      wr_hit = 1'b0;
    end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_CHROMA) begin
      wr_hit = 1'b1;
    end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_CHROMA) begin
      wr_hit = 1'b1;
    end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_HANC) begin
      wr_hit = 1'b1;
    end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_HANC) begin
      wr_hit = 1'b1;
    end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_MODE) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ccb_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ccb_pkg::RESP_OKAY : ccb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  // Per-channel storage and field-start selection
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [7:0] CH_BASE = 8'(c) * ccb_pkg::CH_STRIDE;
    logic wsel;
    assign wsel = wr_go && wr_hit && ((aw_addr & ~ccb_pkg::OFS_MASK) == CH_BASE);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        top_field_chroma_base[c]    <= ccb_pkg::BASE_RESET;
        bottom_field_chroma_base[c] <= ccb_pkg::BASE_RESET;
        top_field_hanc_base[c]      <= ccb_pkg::BASE_RESET;
        bottom_field_hanc_base[c]   <= ccb_pkg::BASE_RESET;
        yc_mux_mode[c]              <= 1'b0;
      end else if (wsel) begin
        if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_CHROMA) begin
          top_field_chroma_base[c] <= merge(top_field_chroma_base[c],
                                            w_data, w_strb);
        end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_CHROMA) begin
          bottom_field_chroma_base[c] <= merge(bottom_field_chroma_base[c],
                                               w_data, w_strb);
        end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_HANC) begin
          top_field_hanc_base[c] <= merge(top_field_hanc_base[c],
                                          w_data, w_strb);
        end else if ((aw_addr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_HANC) begin
          bottom_field_hanc_base[c] <= merge(bottom_field_hanc_base[c],
                                             w_data, w_strb);
        end else if (w_strb[0]) begin
          yc_mux_mode[c] <= w_data[ccb_pkg::MODE_YC_MUX_BIT];
        end
      end
    end

    // Latched at field start so mid-field writes never move the writer
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        field_base[c] <= '0;
        field_cur[c]  <= ccb_pkg::FIELD_TOP;
      end else if (field_start[c]) begin
        field_cur[c] <= field_is_bottom[c];
        field_base[c].chroma_base <= field_is_bottom[c] ?
          bottom_field_chroma_base[c] : top_field_chroma_base[c];
        field_base[c].hanc_base <= field_is_bottom[c] ?
          bottom_field_hanc_base[c] : top_field_hanc_base[c];
        // Channel 0 chroma bases only matter in multiplexed Y/C
        field_base[c].chroma_valid <= (c != 0) || yc_mux_mode[c];
      end
    end
  end

  // Read side
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if ((s_axi_araddr & ~ccb_pkg::OFS_MASK) == 8'(c) * ccb_pkg::CH_STRIDE) begin
        rd_hit = 1'b1;
        if ((s_axi_araddr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_CHROMA) begin
          rd_word = top_field_chroma_base[c];
        end else if ((s_axi_araddr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_CHROMA) begin
          rd_word = bottom_field_chroma_base[c];
        end else if ((s_axi_araddr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_TOP_HANC) begin
          rd_word = top_field_hanc_base[c];
        end else if ((s_axi_araddr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_BOT_HANC) begin
          rd_word = bottom_field_hanc_base[c];
        end else if ((s_axi_araddr & ccb_pkg::OFS_MASK) == ccb_pkg::OFS_MODE) begin
          rd_word = {30'h0, field_cur[c], yc_mux_mode[c]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ccb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? ccb_pkg::RESP_OKAY : ccb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Assertions
  top_chroma_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] && !field_is_bottom[0] |=>
      field_base[0].chroma_base == $past(top_field_chroma_base[0]))
    else $error("top chroma base not selected");
  bot_hanc_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] && field_is_bottom[0] |=>
      field_base[0].hanc_base == $past(bottom_field_hanc_base[0]))
    else $error("bottom hanc base not selected");
  ch0_chroma_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] |=> field_base[0].chroma_valid == $past(yc_mux_mode[0]))
    else $error("channel 0 chroma gating wrong");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  hold_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !field_start[0] |=> $stable(field_base[0]))
    else $error("base moved without field start");
  full_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_hit && aw_addr == ccb_pkg::OFS_TOP_HANC && w_strb == 4'hF
      |=> top_field_hanc_base[0] == $past(w_data))
    else $error("top hanc write lost");

  // Write steps: both halves held, then the response
  sequence bad_wr_s;
    wr_go && !wr_hit;
  endsequence
  sequence err_resp_s;
    s_axi_bvalid && s_axi_bresp == ccb_pkg::RESP_SLVERR;
  endsequence

  wr_err_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bad_wr_s |=> err_resp_s)
    else $error("unmapped write not refused");
  aw_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  top_hanc_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] && !field_is_bottom[0] |=>
      field_base[0].hanc_base == $past(top_field_hanc_base[0]))
    else $error("top hanc base not selected");
  bot_chroma_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] && field_is_bottom[0] |=>
      field_base[0].chroma_base == $past(bottom_field_chroma_base[0]))
    else $error("bottom chroma base not selected");
  field_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
    field_start[0] |=> field_cur[0] == $past(field_is_bottom[0]))
    else $error("current field not tracked");
  mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_hit && aw_addr == ccb_pkg::OFS_MODE && w_strb[0]
      |=> yc_mux_mode[0] == $past(w_data[ccb_pkg::MODE_YC_MUX_BIT]))
    else $error("format bit write lost");
  top_chroma_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_hit && aw_addr == ccb_pkg::OFS_TOP_CHROMA && w_strb == 4'hF
      |=> top_field_chroma_base[0] == $past(w_data))
    else $error("top chroma write lost");
  bot_chroma_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_hit && aw_addr == ccb_pkg::OFS_BOT_CHROMA && w_strb == 4'hF
      |=> bottom_field_chroma_base[0] == $past(w_data))
    else $error("bottom chroma write lost");
  bot_hanc_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_hit && aw_addr == ccb_pkg::OFS_BOT_HANC && w_strb == 4'hF
      |=> bottom_field_hanc_base[0] == $past(w_data))
    else $error("bottom hanc write lost");

  // Other channels keep their chroma bases whatever the format
  if (NCH > 1) begin : g_ch1_chk
    ch1_chroma_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      field_start[1] |=> field_base[1].chroma_valid)
      else $error("channel 1 chroma gated");
    ch1_bot_chroma_a: assert property (@(posedge aclk) disable iff (!aresetn)
      field_start[1] && field_is_bottom[1] |=>
        field_base[1].chroma_base == $past(bottom_field_chroma_base[1]))
      else $error("channel 1 bottom chroma wrong");
  end
endmodule // ccb_regs

// file: test/tb.sv
// Self-checking bench for the chroma and hanc area start registers
`timescale 1ns/1ps
module tb;
  logic                             aclk     = 1'b0;
  logic                             aresetn  = 1'b0;
  logic [7:0]                       awaddr   = 8'h00;
  logic                             awvalid  = 1'b0;
  logic                             awready;
  logic [31:0]                      wdata    = 32'h0000_0000;
  logic [3:0]                       wstrb    = 4'h0;
  logic                             wvalid   = 1'b0;
  logic                             wready;
  logic [1:0]                       bresp;
  logic                             bvalid;
  logic                             bready   = 1'b0;
  logic [7:0]                       araddr   = 8'h00;
  logic                             arvalid  = 1'b0;
  logic                             arready;
  logic [31:0]                      rdata;
  logic [1:0]                       rresp;
  logic                             rvalid;
  logic                             rready   = 1'b0;
  logic [1:0]                       fstart   = 2'h0;
  logic [1:0]                       fbottom  = 2'h0;
  ccb_pkg::ccb_field_base_t [1:0]   fbase;
  int                               err_count  = 0;
  int                               num_checks = 0;
  int                               cycles     = 0;

  ccb_regs #(.NCH(2)) ccb_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .field_start(fstart), .field_is_bottom(fbottom), .field_base(fbase)
  );

  always #25 aclk = ~aclk;

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Low bits deliberately unaligned: the device must keep all 32 bits
  function automatic logic [31:0] pat(input int c, input int r);
    return 32'h5A3C_9E07 + c * 32'h0101_0000 + r * 32'h0000_0111;
  endfunction

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, exp_resp});
  endtask

  task automatic t_reset_and_rw();
    logic [1:0] r;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        rd_check(8'(c * 32 + k * 4), 32'h0000_0000, ccb_pkg::RESP_OKAY);
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++) begin
        axi_wr(8'(c * 32 + k * 4), pat(c, k), 4'hF, r);
        check({30'h0, r}, {30'h0, ccb_pkg::RESP_OKAY});
      end
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
        rd_check(8'(c * 32 + k * 4), pat(c, k), ccb_pkg::RESP_OKAY);
  endtask

  task automatic field(input int c, input logic bot, input logic [31:0] ec,
                       input logic [31:0] eh, input logic ev);
    @(posedge aclk);
    fstart[c]  <= 1'b1;
    fbottom[c] <= bot;
    @(posedge aclk);
    fstart <= 2'h0;
    @(posedge aclk);
    #1;
    check(fbase[c].chroma_base, ec);
    check(fbase[c].hanc_base, eh);
    check({31'h0, fbase[c].chroma_valid}, {31'h0, ev});
  endtask

  task automatic t_fields();
    logic [1:0] r;
    field(1, 1'b0, pat(1, 0), pat(1, 2), 1'b1);
    field(1, 1'b1, pat(1, 1), pat(1, 3), 1'b1);
    field(0, 1'b0, pat(0, 0), pat(0, 2), 1'b0);
    axi_wr(ccb_pkg::OFS_MODE, 32'h0000_0001, 4'hF, r);
    field(0, 1'b1, pat(0, 1), pat(0, 3), 1'b1);
    rd_check(ccb_pkg::OFS_MODE, 32'h0000_0003, ccb_pkg::RESP_OKAY);
  endtask

  task automatic t_aligned();
    logic [1:0] r;
    // Sub-picture width 10h: chroma starts keep four low bits clear
    axi_wr(8'h20, 32'h0012_3400, 4'hF, r);
    axi_wr(8'h24, 32'h0045_6780, 4'hF, r);
    // Hanc starts on 8-byte boundaries in every mode
    axi_wr(8'h28, 32'h0ABC_DEF8, 4'hF, r);
    axi_wr(8'h2C, 32'h0ABC_0008, 4'hF, r);
    field(1, 1'b0, 32'h0012_3400, 32'h0ABC_DEF8, 1'b1);
    field(1, 1'b1, 32'h0045_6780, 32'h0ABC_0008, 1'b1);
    rd_check(8'h30, 32'h0000_0002, ccb_pkg::RESP_OKAY);
  endtask

  task automatic t_strb_and_err();
    logic [1:0]  r;
    logic [31:0] e;
    e = pat(1, 2);
    e[15:8] = 8'h56;
    axi_wr(8'h28, 32'h1234_5678, 4'h2, r);
    check({30'h0, r}, {30'h0, ccb_pkg::RESP_OKAY});
    rd_check(8'h28, e, ccb_pkg::RESP_OKAY);
    // Unmapped hole and a channel beyond the configured count
    axi_wr(8'h14, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, ccb_pkg::RESP_SLVERR});
    axi_wr(8'h40, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, ccb_pkg::RESP_SLVERR});
    rd_check(8'h40, 32'h0000_0000, ccb_pkg::RESP_SLVERR);
    rd_check(8'h00, pat(0, 0), ccb_pkg::RESP_OKAY);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_and_rw();
    t_fields();
    t_strb_and_err();
    t_aligned();
    give_verdict();
  end
endmodule // tb
